// File: shared/fsv_pkg.sv
// Purpose: shared constants and types for the flyback start-up and fault supervisor
// Assumes: 20 MHz system clock, comparator results already digitised
// Notes:   all timing counts derive from the printed times and the clock rate
package fsv_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ     = 20_000_000;
  localparam int unsigned CS_MIN_WIN_NS   = 4000;
  // longest time rounds down
  localparam int unsigned CS_MIN_WIN_CYC  = (CS_MIN_WIN_NS * (CLK_FREQ_HZ / 1_000_000)) / 1000;
  localparam int unsigned WIN_CNT_W       = 8;

  // ****************************************
  // fault qualification counts
  // ****************************************
  localparam int unsigned PROBE_CYCLES    = 3;
  localparam int unsigned FAULT_CONSEC    = 3;
  localparam int unsigned CNT_W           = 2;

  // ****************************************
  // supervisor states
  // ****************************************
  typedef enum logic [2:0] {
    FSV_IDLE    = 3'b000,
    FSV_PROBE   = 3'b001,
    FSV_RUN     = 3'b010,
    FSV_RESTART = 3'b011,
    FSV_SINGLE  = 3'b100
  } fsv_state_e;

endpackage

// File: src/fsv_consec_counter.sv
// Purpose: consecutive switching-cycle fault qualifier
// Assumes: cycleEnd is a one-cycle pulse marking the close of a switching cycle
// Notes:   qualified stays high until clrCnt
`timescale 1ns/10ps
module fsv_consec_counter #(
  parameter int unsigned LIMIT = 3,
  parameter int unsigned W     = 2
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // cycle events
  input  wire logic cycleEnd,
  input  wire logic condMet,
  input  wire logic clrCnt,
  // result
  output logic      qualified
);

  logic [W-1:0] count_ff;

  always_ff @(posedge clock) begin
    if (sys_rst || clrCnt) begin
      count_ff  <= '0;
      qualified <= 1'b0;
    end else if (cycleEnd) begin
      if (!condMet) begin
        count_ff <= '0; // RULE_18
      end else if (count_ff == W'(LIMIT - 1)) begin
        qualified <= 1'b1;
      end else begin
        count_ff <= count_ff + 1'b1;
      end
    end
  end

endmodule

// File: src/fsv_supervisor.sv
// Purpose: start-up sequencing and fault supervision of a primary-side flyback controller
// Assumes: all comparator inputs come from the analog domain and are synchronised here
// Notes:   switching-cycle timing comes from gateOnReq and demag/blanking events
//
// Notes on behaviour
// RULE_01: stay idle until supply reaches turn-on, then enable and start switching.
// RULE_02: first three cycles after enable clamp peak current to minimum.
// RULE_03: leave probing for normal conversion only with line good and no fault.
// RULE_04: supply below turn-off stops switching; resume only at turn-on again.
// RULE_05: thermistor pin low before turn-on; source current enabled after turn-on.
// RULE_06: below maximum peak current, enter wait state between conversion intervals.
// RULE_07: source current off during wait, back on when run resumes.
// RULE_08: feedback sample over limit three consecutive cycles asserts over-voltage fault.
// RULE_09: restart fault stops switching, keeps run bias until turn-off, then restarts.
// RULE_10: line adequacy judged from feedback-pin current during switch on-time only.
// RULE_11: no line-run current within three start cycles triggers restart fault.
// RULE_12: line below stop threshold three consecutive cycles triggers restart fault.
// RULE_13: over-current counted between blanking end and demag end; three cycles fault.
// RULE_14: first cycle only, sense below minimum within window ends cycle, restart fault.
// RULE_15: after divider fault each restart issues only a single gate on-time.
// RULE_16: thermistor sampled at demag end; three samples below level fault.
// RULE_17: die over-temperature starts restart cycle; repeats while still set.
// RULE_18: counters clear on a failing cycle and on entry to start state.
// RULE_19: all faults share one restart sequencer latched until supply turn-off.
`timescale 1ns/10ps
module fsv_supervisor
  import fsv_pkg::*;
#(
  parameter int unsigned PROBE_N  = fsv_pkg::PROBE_CYCLES,
  parameter int unsigned CONSEC_N = fsv_pkg::FAULT_CONSEC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // supply comparators
  input  wire logic        supplyAboveOn,
  input  wire logic        supplyAboveOff,
  // switching-cycle timing from the control law
  input  wire logic        gateOnReq,
  input  wire logic        gateOffReq,
  input  wire logic        blankingDone,
  input  wire logic        demagDone,
  input  wire logic        peakBelowMax,
  // feedback sense pin comparators
  input  wire logic        fbOverVoltage,
  input  wire logic        lineAboveRun,
  input  wire logic        lineBelowStop,
  input  wire logic        fbDividerOpen,
  // current sense comparators
  input  wire logic        senseOverCurrent,
  input  wire logic        senseAboveMin,
  // thermal
  input  wire logic        ntcBelowShutdown,
  input  wire logic        dieOverTemp,
  // outputs
  output logic             gateDriveOutput,
  output logic             controllerEnable,
  output logic             minPeakClamp,
  output logic             normalRun,
  output logic             waitState,
  output logic             startupSourceEn,
  output logic             runBias,
  output logic             overVoltageFault,
  output logic             restartFault,
  output fsv_pkg::fsv_state_e stateOut
);

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int unsigned NIN = 15;
  logic [NIN-1:0] rawIn;
  logic [NIN-1:0] syncA_ff;
  logic [NIN-1:0] syncB_ff;

  assign rawIn = {supplyAboveOn, supplyAboveOff, gateOnReq, gateOffReq, blankingDone, demagDone,
                  peakBelowMax, fbOverVoltage, lineAboveRun, lineBelowStop, fbDividerOpen,
                  senseOverCurrent, senseAboveMin, ntcBelowShutdown, dieOverTemp};

  // reset-free data path, only the second stage is read
  always_ff @(posedge clock) begin
    syncA_ff <= rawIn;
    syncB_ff <= syncA_ff;
  end

  logic sOn, sOff, sGateOn, sGateOff, sBlank, sDemag, sPeakLow, sOv, sRun, sStop, sDiv, sOc, sCsMin, sNtc, sOt;
  assign {sOn, sOff, sGateOn, sGateOff, sBlank, sDemag, sPeakLow, sOv, sRun, sStop, sDiv,
          sOc, sCsMin, sNtc, sOt} = syncB_ff;

  // ****************************************
  // edge detection on synchronised events
  // ****************************************
  logic gateOnD_ff, demagD_ff, blankD_ff;
  logic gateOnEdge, demagEdge, blankEdge;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      gateOnD_ff <= 1'b0;
      demagD_ff  <= 1'b0;
      blankD_ff  <= 1'b0;
    end else begin
      gateOnD_ff <= sGateOn;
      demagD_ff  <= sDemag;
      blankD_ff  <= sBlank;
    end
  end

  assign gateOnEdge = sGateOn & ~gateOnD_ff;
  assign demagEdge  = sDemag & ~demagD_ff;
  assign blankEdge  = sBlank & ~blankD_ff;

  // ****************************************
  // state and cycle bookkeeping
  // ****************************************
  fsv_state_e state_ff, nxt_state;
  logic [CNT_W:0]     probeCnt_ff;
  logic               lineOk_ff;
  logic               ocSeen_ff;
  logic               onTime_ff;
  logic               csMinSeen_ff;
  logic               inOcWindow_ff;
  logic [WIN_CNT_W-1:0] winCnt_ff;
  logic               dividerLatch_ff;
  logic               singleDone_ff;
  logic               afterDemag_ff;
  logic               switchNext;
  logic               enterStart;
  logic               cycleEnd;
  logic               ovQual, stopQual, ocQual, ntcQual;
  logic               csShortFault;
  logic               anyFault;
  logic               probeDone;
  logic               switching;

  assign switching  = (state_ff == FSV_PROBE) || (state_ff == FSV_RUN) || (state_ff == FSV_SINGLE);
  assign cycleEnd   = demagEdge && switching;
  assign enterStart = (state_ff == FSV_IDLE) && sOn;
  assign probeDone  = (probeCnt_ff == (CNT_W+1)'(PROBE_N));

  // sense-min window on the very first start cycle
  always_ff @(posedge clock) begin
    if (sys_rst || enterStart) begin
      winCnt_ff    <= '0;
      csMinSeen_ff <= 1'b0;
    end else if (onTime_ff && probeCnt_ff == '0 && state_ff == FSV_PROBE) begin
      if (sCsMin) begin
        csMinSeen_ff <= 1'b1;
      end
      if (winCnt_ff != WIN_CNT_W'(CS_MIN_WIN_CYC)) begin
        winCnt_ff <= winCnt_ff + 1'b1;
      end
    end
  end

  assign csShortFault = (state_ff == FSV_PROBE) && (probeCnt_ff == '0) && onTime_ff &&
                        !csMinSeen_ff && !sCsMin && (winCnt_ff == WIN_CNT_W'(CS_MIN_WIN_CYC)); // RULE_14

  // on-time tracking, line sampling and over-current window
  always_ff @(posedge clock) begin
    if (sys_rst || enterStart) begin
      onTime_ff     <= 1'b0;
      afterDemag_ff <= 1'b0;
      lineOk_ff     <= 1'b0;
      ocSeen_ff     <= 1'b0;
      inOcWindow_ff <= 1'b0;
    end else begin
      if (gateOnEdge && switching) begin
        onTime_ff <= 1'b1;
      end else if (sGateOff || csShortFault) begin
        onTime_ff <= 1'b0;
      end
      // demag end until next on-time is the only span where wait may start
      if (gateOnEdge && switching) begin
        afterDemag_ff <= 1'b0;
      end else if (cycleEnd) begin
        afterDemag_ff <= 1'b1;
      end
      if (onTime_ff && sRun) begin
        lineOk_ff <= 1'b1; // RULE_10
      end
      if (blankEdge) begin
        inOcWindow_ff <= 1'b1;
      end else if (demagEdge) begin
        inOcWindow_ff <= 1'b0;
      end
      if (cycleEnd) begin
        ocSeen_ff <= 1'b0;
      end else if ((inOcWindow_ff || blankEdge) && sOc) begin
        ocSeen_ff <= 1'b1; // RULE_13
      end
    end
  end

  // stop-level flag gathered during the on-time
  logic stopSeen_ff;
  always_ff @(posedge clock) begin
    if (sys_rst || cycleEnd) begin
      stopSeen_ff <= 1'b0;
    end else if (onTime_ff && sStop) begin
      stopSeen_ff <= 1'b1; // RULE_10
    end
  end

  // probe cycle counter
  always_ff @(posedge clock) begin
    if (sys_rst || enterStart) begin
      probeCnt_ff <= '0;
    end else if (cycleEnd && state_ff == FSV_PROBE && !probeDone) begin
      probeCnt_ff <= probeCnt_ff + 1'b1;
    end
  end

  // ****************************************
  // consecutive-cycle qualifiers
  // ****************************************
  fsv_consec_counter #(.LIMIT(CONSEC_N), .W(CNT_W)) uOv (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .cycleEnd  (cycleEnd),
    .condMet   (sOv),
    .clrCnt    (enterStart),
    .qualified (ovQual)
  ); // RULE_08
  fsv_consec_counter #(.LIMIT(CONSEC_N), .W(CNT_W)) uStop (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .cycleEnd  (cycleEnd && state_ff == FSV_RUN),
    .condMet   (stopSeen_ff),
    .clrCnt    (enterStart),
    .qualified (stopQual)
  ); // RULE_12
  fsv_consec_counter #(.LIMIT(CONSEC_N), .W(CNT_W)) uOc (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .cycleEnd  (cycleEnd),
    .condMet   (ocSeen_ff),
    .clrCnt    (enterStart),
    .qualified (ocQual)
  ); // RULE_13
  fsv_consec_counter #(.LIMIT(CONSEC_N), .W(CNT_W)) uNtc (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .cycleEnd  (cycleEnd),
    .condMet   (sNtc),
    .clrCnt    (enterStart),
    .qualified (ntcQual)
  ); // RULE_16

  // ****************************************
  // shared fault sequencer
  // ****************************************
  // every source funnels here so one latch owns the restart
  assign anyFault = ovQual || stopQual || ocQual || ntcQual || csShortFault || sOt || sDiv ||
                    (state_ff == FSV_PROBE && probeDone && !lineOk_ff); // RULE_19 RULE_11 RULE_17

  // divider fault remembered across supply cycles
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dividerLatch_ff <= 1'b0;
    end else if (sDiv && switching) begin
      dividerLatch_ff <= 1'b1;
    end else if (state_ff == FSV_SINGLE && cycleEnd && !sDiv) begin
      dividerLatch_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || enterStart) begin
      singleDone_ff <= 1'b0;
    end else if (state_ff == FSV_SINGLE && sGateOff && onTime_ff) begin
      singleDone_ff <= 1'b1; // RULE_15
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      FSV_IDLE: begin
        if (sOn) begin
          nxt_state = dividerLatch_ff ? FSV_SINGLE : FSV_PROBE; // RULE_01 RULE_15
        end
      end
      FSV_PROBE: begin
        if (!sOff) begin
          nxt_state = FSV_IDLE; // RULE_04
        end else if (anyFault) begin
          nxt_state = FSV_RESTART; // RULE_11 RULE_14
        end else if (probeDone && lineOk_ff) begin
          nxt_state = FSV_RUN; // RULE_03
        end
      end
      FSV_RUN: begin
        if (!sOff) begin
          nxt_state = FSV_IDLE; // RULE_04
        end else if (anyFault) begin
          nxt_state = FSV_RESTART; // RULE_09
        end
      end
      FSV_SINGLE: begin
        if (!sOff) begin
          nxt_state = FSV_IDLE;
        // leave at demag end so the divider latch gets its sample
        end else if (singleDone_ff && cycleEnd) begin
          nxt_state = FSV_RESTART; // RULE_15
        end
      end
      FSV_RESTART: begin
        if (!sOff) begin
          nxt_state = FSV_IDLE; // RULE_09 RULE_19
        end
      end
      default: begin
        nxt_state = FSV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= FSV_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  logic wait_nxt;
  assign switchNext = (nxt_state == FSV_PROBE) || (nxt_state == FSV_RUN) || (nxt_state == FSV_SINGLE);
  // wait starts after demag, so the thermistor sample at demag end still sees the source
  assign wait_nxt = (nxt_state == FSV_RUN) && sPeakLow && afterDemag_ff && !onTime_ff && !gateOnEdge; // RULE_06

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      gateDriveOutput  <= 1'b0;
      controllerEnable <= 1'b0;
      minPeakClamp     <= 1'b0;
      normalRun        <= 1'b0;
      waitState        <= 1'b0;
      startupSourceEn  <= 1'b0;
      runBias          <= 1'b0;
      overVoltageFault <= 1'b0;
      restartFault     <= 1'b0;
      stateOut         <= FSV_IDLE;
    end else begin
      // faults already steer nxt_state away; single mode must still get its one on-time
      gateDriveOutput  <= onTime_ff && switchNext && !singleDone_ff;
      controllerEnable <= (nxt_state != FSV_IDLE); // RULE_01
      minPeakClamp     <= (nxt_state == FSV_PROBE) || (nxt_state == FSV_SINGLE); // RULE_02
      normalRun        <= (nxt_state == FSV_RUN);
      waitState        <= wait_nxt;
      // low before turn-on, off in wait, otherwise sourcing
      startupSourceEn  <= (nxt_state != FSV_IDLE) && !wait_nxt; // RULE_05 RULE_07
      runBias          <= (nxt_state != FSV_IDLE); // RULE_09
      overVoltageFault <= ovQual; // RULE_08
      restartFault     <= (nxt_state == FSV_RESTART); // RULE_19
      stateOut         <= nxt_state;
    end
  end

endmodule

// File: tb/fsv_stage_model.sv
// Purpose: power stage and sense network seen by the supervisor
// Assumes: gate drive is a registered level on clock
// Notes:   sense ramps in clocks, not real time
`timescale 1ns/10ps
module fsv_stage_model (
  // clock
  input  wire logic clock,
  // gate and pin source
  input  wire logic gateOn,
  input  wire logic srcEn,
  // scenario controls
  input  wire logic csShort,
  input  wire logic ocLoad,
  input  wire logic ntcHot,
  // comparator results
  output logic      senseAboveMin,
  output logic      senseOverCurrent,
  output logic      ntcBelow
);
  // ********
  // current ramp
  // ********
  logic [3:0] rampCnt;
  always_ff @(posedge clock) begin
    rampCnt <= !gateOn ? 4'h0 : (rampCnt == 4'hf) ? rampCnt : rampCnt + 4'h1;
  end
  // shorted sense never climbs
  assign senseAboveMin    = !csShort && (rampCnt > 4'h5);
  // open sense pin pulls up for the whole cycle
  assign senseOverCurrent = ocLoad;
  // source off leaves the pin near ground
  assign ntcBelow         = ntcHot || !srcEn;
endmodule

// File: tb/fsv_supervisor_monitor.sv
// Purpose: port checks on the supervisor
// Assumes: pin to output latency of three edges
// Notes:   supply repetition keeps one edge of margin
`timescale 1ns/10ps
module fsv_supervisor_monitor
  import fsv_pkg::*;
#(
  parameter int unsigned PROBE_N  = 3,
  parameter int unsigned CONSEC_N = 3
) (
  // clock and reset
  input wire logic                clock,
  input wire logic                sys_rst,
  // watched signals
  input wire logic                supplyAboveOff,
  input wire logic                gateDriveOutput,
  input wire logic                controllerEnable,
  input wire logic                minPeakClamp,
  input wire logic                normalRun,
  input wire logic                waitState,
  input wire logic                startupSourceEn,
  input wire logic                runBias,
  input wire logic                overVoltageFault,
  input wire logic                restartFault,
  input wire fsv_pkg::fsv_state_e stateOut
);
  import fsv_pkg::*;
  // ********
  // properties
  // ********
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence supplyGone; !supplyAboveOff [*5]; endsequence
  sequence ovRaised; $rose(overVoltageFault); endsequence
  sequence enableRise; $rose(controllerEnable); endsequence
  sequence supplyHeld; supplyAboveOff && $past(supplyAboveOff) && $past(supplyAboveOff, 2); endsequence
  idle_no_gate_a: assert property (stateOut == FSV_IDLE |-> !gateDriveOutput && !runBias)
    else $error("gate or bias active while idle");
  enable_tracks_a: assert property (controllerEnable == (stateOut != FSV_IDLE))
    else $error("enable disagrees with state");
  start_clamp_a: assert property (enableRise |-> minPeakClamp && stateOut inside {FSV_PROBE, FSV_SINGLE})
    else $error("start without minimum peak clamp");
  run_unclamped_a: assert property (normalRun |-> !minPeakClamp && stateOut == FSV_RUN)
    else $error("normal run while clamped");
  pin_low_a: assert property (stateOut == FSV_IDLE |-> !startupSourceEn)
    else $error("pin source on before turn-on");
  wait_source_a: assert property (waitState |-> !startupSourceEn && normalRun && !gateDriveOutput)
    else $error("wait state with source or gate on");
  supply_off_a: assert property (supplyGone |-> stateOut == FSV_IDLE && !gateDriveOutput)
    else $error("switching with supply below turn-off");
  restart_hold_a: assert property (restartFault |-> runBias && !gateDriveOutput && stateOut == FSV_RESTART)
    else $error("restart without run bias or with gate");
  ov_restart_a: assert property (ovRaised |-> ##[0:3] restartFault)
    else $error("over-voltage without restart");
  restart_latch_a: assert property (restartFault and supplyHeld |=> restartFault)
    else $error("restart released before turn-off");
endmodule
bind fsv_supervisor fsv_supervisor_monitor #(.PROBE_N(PROBE_N), .CONSEC_N(CONSEC_N)) mon (
  .clock(clock), .sys_rst(sys_rst), .supplyAboveOff(supplyAboveOff), .gateDriveOutput(gateDriveOutput),
  .controllerEnable(controllerEnable), .minPeakClamp(minPeakClamp), .normalRun(normalRun),
  .waitState(waitState), .startupSourceEn(startupSourceEn), .runBias(runBias),
  .overVoltageFault(overVoltageFault), .restartFault(restartFault), .stateOut(stateOut));

// File: tb/flyback_startup_fault_supervisor_tb.sv
// Purpose: self-checking bench for the start-up and fault supervisor
// Assumes: inputs change on the falling edge of a 50 ns clock
// Notes:   fault kinds walked from a table, cycle gaps drawn at random
`timescale 1ns/10ps
module flyback_startup_fault_supervisor_tb;
  import fsv_pkg::*;
  // ********
  // signals
  // ********
  logic       clock, sys_rst, supplyAboveOn, supplyAboveOff, gateOnReq, gateOffReq, blankingDone;
  logic       demagDone, peakBelowMax, fbOverVoltage, lineAboveRun, lineBelowStop, fbDividerOpen;
  logic       senseOverCurrent, senseAboveMin, ntcBelowShutdown, dieOverTemp, csShort, ocLoad, ntcHot;
  logic       gateDriveOutput, controllerEnable, minPeakClamp, normalRun, waitState, startupSourceEn;
  logic       runBias, overVoltageFault, restartFault, gatePrev;
  fsv_state_e stateOut;
  int         errCount, testsRun, gateRises;
  integer     seed;
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    gatePrev <= gateDriveOutput;
    if (gateDriveOutput === 1'b1 && gatePrev === 1'b0) gateRises++;
  end
  fsv_supervisor dut (
    .clock(clock), .sys_rst(sys_rst), .supplyAboveOn(supplyAboveOn), .supplyAboveOff(supplyAboveOff),
    .gateOnReq(gateOnReq), .gateOffReq(gateOffReq), .blankingDone(blankingDone), .demagDone(demagDone),
    .peakBelowMax(peakBelowMax), .fbOverVoltage(fbOverVoltage), .lineAboveRun(lineAboveRun),
    .lineBelowStop(lineBelowStop), .fbDividerOpen(fbDividerOpen), .senseOverCurrent(senseOverCurrent),
    .senseAboveMin(senseAboveMin), .ntcBelowShutdown(ntcBelowShutdown), .dieOverTemp(dieOverTemp),
    .gateDriveOutput(gateDriveOutput), .controllerEnable(controllerEnable), .minPeakClamp(minPeakClamp),
    .normalRun(normalRun), .waitState(waitState), .startupSourceEn(startupSourceEn), .runBias(runBias),
    .overVoltageFault(overVoltageFault), .restartFault(restartFault), .stateOut(stateOut));
  fsv_stage_model stage (
    .clock(clock), .gateOn(gateDriveOutput), .srcEn(startupSourceEn), .csShort(csShort), .ocLoad(ocLoad),
    .ntcHot(ntcHot), .senseAboveMin(senseAboveMin), .senseOverCurrent(senseOverCurrent),
    .ntcBelow(ntcBelowShutdown));
  // ********
  // tasks
  // ********
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic summarize();
    if (errCount == 0 && testsRun > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bounded poll; a miss ends the run
  task automatic waitSt(input fsv_state_e s);
    int n;
    n = 0;
    while (stateOut !== s && n < 300) begin
      step(1);
      n++;
    end
    check("state", stateOut, s);
    if (stateOut !== s) summarize();
  endtask
  // order: on request, off request, blanking end, demag end
  task automatic swCycle();
    int gap;
    gap = 4 + ($unsigned($random(seed)) % 4);
    gateOnReq = 1'b1;
    step(gap + 6);
    gateOffReq = 1'b1;
    gateOnReq = 1'b0;
    step(gap);
    blankingDone = 1'b1;
    step(gap);
    demagDone = 1'b1;
    step(gap);
    {gateOffReq, blankingDone, demagDone} = 3'h0;
    step(12);
  endtask
  task automatic powerUp(input fsv_state_e s);
    supplyAboveOff = 1'b1;
    supplyAboveOn = 1'b1;
    waitSt(s);
  endtask
  task automatic powerDown();
    supplyAboveOn = 1'b0;
    supplyAboveOff = 1'b0;
    waitSt(FSV_IDLE);
  endtask
  task automatic setFault(input int k, input logic v);
    case (k)
      0: fbOverVoltage = v;
      1: {lineBelowStop, lineAboveRun} = {v, !v};
      2: ocLoad = v;
      3: ntcHot = v;
      default: dieOverTemp = v;
    endcase
  endtask
  // ********
  // scenarios
  // ********
  initial begin
    seed = 32'hbb9b;
    {sys_rst, supplyAboveOn, supplyAboveOff, gateOnReq, gateOffReq, blankingDone, demagDone} = 7'h40;
    {peakBelowMax, fbOverVoltage, lineBelowStop, fbDividerOpen, dieOverTemp, csShort, ocLoad, ntcHot} = 8'h00;
    lineAboveRun = 1'b1;
    step(2);
    sys_rst = 1'b0;
    step(20);
    check("idle state", stateOut, FSV_IDLE);
    check("idle source", startupSourceEn, 1'b0);
    powerUp(FSV_PROBE);
    check("start source", startupSourceEn, 1'b1);
    repeat (2) swCycle();
    check("probe clamp", minPeakClamp, 1'b1);
    check("probe run", normalRun, 1'b0);
    swCycle();
    waitSt(FSV_RUN);
    check("run clamp", minPeakClamp, 1'b0);
    for (int i = 0; i < 6; i++) begin
      peakBelowMax = (i < 2) ? !i[0] : 1'($random(seed));
      swCycle();
      check("wait state", waitState, peakBelowMax);
      check("wait source", startupSourceEn, !peakBelowMax);
    end
    peakBelowMax = 1'b0;
    powerDown();
    // a good cycle between fault cycles restarts the count
    for (int f = 0; f < 5; f++) begin
      powerUp(FSV_PROBE);
      repeat (3) swCycle();
      waitSt(FSV_RUN);
      setFault(f, 1'b1);
      if (f < 4) begin
        repeat (2) swCycle();
        setFault(f, 1'b0);
        swCycle();
        setFault(f, 1'b1);
        repeat (2) swCycle();
        check("early fault", restartFault, 1'b0);
        swCycle();
      end
      waitSt(FSV_RESTART);
      check("restart bias", runBias, 1'b1);
      check("ov flag", overVoltageFault, f == 0);
      if (f != 4) setFault(f, 1'b0);
      powerDown();
    end
    powerUp(FSV_RESTART);
    dieOverTemp = 1'b0;
    powerDown();
    lineAboveRun = 1'b0;
    powerUp(FSV_PROBE);
    repeat (2) swCycle();
    check("probe hold", restartFault, 1'b0);
    swCycle();
    waitSt(FSV_RESTART);
    check("gate off", gateDriveOutput, 1'b0);
    lineAboveRun = 1'b1;
    powerDown();
    csShort = 1'b1;
    powerUp(FSV_PROBE);
    // gate request held past the sense window, as the control law would with a shorted pin
    gateOnReq = 1'b1;
    waitSt(FSV_RESTART);
    check("short gate", gateDriveOutput, 1'b0);
    {gateOnReq, csShort} = 2'h0;
    powerDown();
    powerUp(FSV_PROBE);
    repeat (3) swCycle();
    fbDividerOpen = 1'b1;
    waitSt(FSV_RESTART);
    powerDown();
    powerUp(FSV_SINGLE);
    gateRises = 0;
    repeat (2) swCycle();
    check("single on-time", gateRises[2:0], 3'h1);
    waitSt(FSV_RESTART);
    // divider mended: one more single attempt, then a normal start
    fbDividerOpen = 1'b0;
    powerDown();
    powerUp(FSV_SINGLE);
    swCycle();
    waitSt(FSV_RESTART);
    powerDown();
    powerUp(FSV_PROBE);
    summarize();
  end
endmodule
